// ===== hw/ulb_pkg.sv
// What this block does
// - On an unaffected part the receive-timeout raw flag is set on every timeout whatever the mask bit says.
// - On the affected revision the raw flag is set on a timeout only while the mask bit is set.
// - As a LIN master the sync break lasts 13, 14, 15 or 16 bit times for break-length codes 0 to 3.
// - On the affected revision each sync break is one bit time shorter, 12 to 15 bit times for codes 0 to 3.
// - On the affected revision burst DMA requests are withheld while LIN or infrared mode is on.
package ulb_pkg;

	// ************************************************************
	// Widths, break base lengths and reset values
	// ************************************************************
	localparam int BRK_CNT_W = 5;
	localparam int DIV_W = 16;
	localparam logic [BRK_CNT_W-1:0] BRK_BASE_SPEC = 5'h0d;
	localparam logic [BRK_CNT_W-1:0] BRK_BASE_REV = 5'h0c;
	localparam logic RST_RAW_FLAG = 1'h0;
	localparam logic RST_TXD = 1'h1;
	localparam logic [BRK_CNT_W-1:0] RST_BRK_CNT = 5'h00;
	localparam logic [DIV_W-1:0] RST_DIV_CNT = 16'h0000;

	// ************************************************************
	// Break generator states
	// ************************************************************
	typedef enum logic [2:0] {
		BRK_IDLE = 3'b001,
		BRK_LOW = 3'b010,
		BRK_DONE = 3'b100
	} ulb_brk_e;

endpackage : ulb_pkg

// ===== hw/ulb_brk_if.sv
`timescale 1ns/1ps
interface ulb_brk_if;
	import ulb_pkg::*;
	logic start;
	logic [BRK_CNT_W-1:0] len_bits;
	logic line_low;
	logic busy;
	logic done;
	modport ctl (output start, output len_bits,
		input line_low, input busy, input done);
	modport gen (input start, input len_bits,
		output line_low, output busy, output done);
endinterface : ulb_brk_if

// ===== hw/ulb_break_gen.sv
`timescale 1ns/1ps
module ulb_break_gen
	import ulb_pkg::*;
#(
	parameter int BAUD_DIV = 16
) (
	input wire logic clk,
	input wire logic rst_n,
	ulb_brk_if.gen brk
);

	if (BAUD_DIV < 1 || BAUD_DIV > 65535) begin : g_div_check
		$error("BAUD_DIV out of range");
	end

	localparam logic [DIV_W-1:0] DIV_M1 = DIV_W'(BAUD_DIV - 1);

	typedef struct packed {
		ulb_brk_e st;
		logic [BRK_CNT_W-1:0] bit_cnt;
		logic [DIV_W-1:0] div_cnt;
		logic low;
	} ulb_brk_s;

	ulb_brk_s s_q;
	ulb_brk_s s_d;

	// ************************************************************
	// Break sequencer
	// ************************************************************
	always_comb begin
		s_d = s_q;
		unique case (s_q.st)
			BRK_IDLE: begin
				if (brk.start) begin
					s_d.bit_cnt = brk.len_bits - 5'h01;
					s_d.div_cnt = DIV_M1;
					s_d.low = 1'b1;
					s_d.st = BRK_LOW;
				end
			end
			BRK_LOW: begin
				if (s_q.div_cnt == '0) begin
					if (s_q.bit_cnt == '0) begin
						s_d.low = 1'b0;
						s_d.st = BRK_DONE;
					end else begin
						s_d.bit_cnt = s_q.bit_cnt - 5'h01;
						s_d.div_cnt = DIV_M1;
					end
				end else begin
					s_d.div_cnt = s_q.div_cnt - 16'h0001;
				end
			end
			BRK_DONE: begin
				s_d.st = BRK_IDLE;
			end
			default: begin
				s_d.st = BRK_IDLE;
				s_d.low = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '{BRK_IDLE, RST_BRK_CNT, RST_DIV_CNT, 1'b0};
		end else begin
			s_q <= s_d;
		end
	end

	assign brk.line_low = s_q.low;
	assign brk.busy = (s_q.st != BRK_IDLE);
	assign brk.done = (s_q.st == BRK_DONE);

	// ************************************************************
	// Checks
	// ************************************************************
	int low_cnt;
	int exp_cnt;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			low_cnt <= 0;
			exp_cnt <= 0;
		end else if (brk.start && s_q.st == BRK_IDLE) begin
			low_cnt <= 0;
			exp_cnt <= int'(brk.len_bits) * BAUD_DIV;
		end else if (s_q.low) begin
			low_cnt <= low_cnt + 1;
		end
	end

	sequence seq_accept;
		brk.start && s_q.st == BRK_IDLE;
	endsequence

	sequence seq_begin_low;
		brk.line_low && brk.busy;
	endsequence

	a_break_low_length: assert property (
		@(posedge clk) disable iff (!rst_n)
		$fell(brk.line_low) |-> low_cnt == exp_cnt)
		else $error("break low time differs from length times bit");

	a_break_starts: assert property (
		@(posedge clk) disable iff (!rst_n)
		seq_accept |=> seq_begin_low)
		else $error("break did not start after request");

	a_break_done_follows: assert property (
		@(posedge clk) disable iff (!rst_n)
		$fell(brk.line_low) |-> brk.done ##1 !brk.busy)
		else $error("break end not followed by done and idle");

endmodule : ulb_break_gen

// ===== hw/ulb_top.sv
`timescale 1ns/1ps
module ulb_top
	import ulb_pkg::*;
#(
	parameter int BAUD_DIV = 16
) (
	input wire logic MCLK,
	input wire logic RESETN,
	input wire logic REV_AFFECTED,
	input wire logic RX_TIMEOUT_EVT,
	input wire logic RX_TIMEOUT_MASK_BIT,
	input wire logic RX_TIMEOUT_CLR,
	output logic RX_TIMEOUT_RAW_FLAG,
	output logic RX_TIMEOUT_IRQ,
	input wire logic LIN_MASTER_EN,
	input wire logic INFRARED_SERIAL_MODE,
	input wire logic [1:0] BREAK_LENGTH_FIELD,
	input wire logic BREAK_START,
	output logic TXD,
	output logic BREAK_BUSY,
	output logic BREAK_DONE,
	input wire logic RX_DATA_AVAIL,
	input wire logic RX_BURST_AVAIL,
	input wire logic TX_SPACE_AVAIL,
	input wire logic TX_BURST_SPACE,
	output logic DMA_RX_SREQ,
	output logic DMA_RX_BREQ,
	output logic DMA_TX_SREQ,
	output logic DMA_TX_BREQ
);

	typedef struct packed {
		logic raw;
		logic irq;
		logic txd;
		logic busy;
		logic done;
		logic rx_sreq;
		logic rx_breq;
		logic tx_sreq;
		logic tx_breq;
	} ulb_top_s;

	ulb_top_s s_q;
	ulb_top_s s_d;
	ulb_brk_if brk ();

	logic to_allowed;
	logic to_set;
	logic burst_block;

	// ************************************************************
	// Break generator
	// ************************************************************
	ulb_break_gen #(
		.BAUD_DIV(BAUD_DIV)
	) u_brk (
		.clk(MCLK),
		.rst_n(RESETN),
		.brk(brk)
	);

	assign brk.len_bits = (REV_AFFECTED ? BRK_BASE_REV : BRK_BASE_SPEC)
		+ {3'h0, BREAK_LENGTH_FIELD};
	assign brk.start = BREAK_START && LIN_MASTER_EN && !brk.busy;

	// ************************************************************
	// Timeout flag and request logic
	// ************************************************************
	// Unaffected part ignores mask
	assign to_allowed = !REV_AFFECTED || RX_TIMEOUT_MASK_BIT;
	assign to_set = RX_TIMEOUT_EVT && to_allowed;
	// Burst withheld in LIN or infrared on the affected revision
	assign burst_block = REV_AFFECTED
		&& (LIN_MASTER_EN || INFRARED_SERIAL_MODE);

	always_comb begin
		s_d = s_q;
		// Set wins over a clear in the same cycle
		if (to_set) begin
			s_d.raw = 1'b1;
		end else if (RX_TIMEOUT_CLR) begin
			s_d.raw = 1'b0;
		end
		s_d.irq = s_d.raw && RX_TIMEOUT_MASK_BIT;
		s_d.txd = !brk.line_low;
		s_d.busy = brk.busy;
		s_d.done = brk.done;
		s_d.rx_sreq = RX_DATA_AVAIL;
		s_d.rx_breq = RX_BURST_AVAIL && !burst_block;
		s_d.tx_sreq = TX_SPACE_AVAIL;
		s_d.tx_breq = TX_BURST_SPACE && !burst_block;
	end

	always_ff @(posedge MCLK or negedge RESETN) begin
		if (!RESETN) begin
			s_q <= '{RST_RAW_FLAG, 1'b0, RST_TXD, 1'b0, 1'b0,
				1'b0, 1'b0, 1'b0, 1'b0};
		end else begin
			s_q <= s_d;
		end
	end

	assign RX_TIMEOUT_RAW_FLAG = s_q.raw;
	assign RX_TIMEOUT_IRQ = s_q.irq;
	assign TXD = s_q.txd;
	assign BREAK_BUSY = s_q.busy;
	assign BREAK_DONE = s_q.done;
	assign DMA_RX_SREQ = s_q.rx_sreq;
	assign DMA_RX_BREQ = s_q.rx_breq;
	assign DMA_TX_SREQ = s_q.tx_sreq;
	assign DMA_TX_BREQ = s_q.tx_breq;

	// ************************************************************
	// Checks
	// ************************************************************
	a_raw_set_spec: assert property (
		@(posedge MCLK) disable iff (!RESETN)
		RX_TIMEOUT_EVT && !REV_AFFECTED |=> RX_TIMEOUT_RAW_FLAG)
		else $error("timeout not flagged on unaffected part");

	a_raw_gated_rev: assert property (
		@(posedge MCLK) disable iff (!RESETN)
		$rose(RX_TIMEOUT_RAW_FLAG) |->
			$past(RX_TIMEOUT_EVT)
			&& ($past(RX_TIMEOUT_MASK_BIT) || !$past(REV_AFFECTED)))
		else $error("raw timeout flag set without cause");

	a_raw_set_wins: assert property (
		@(posedge MCLK) disable iff (!RESETN)
		to_set && RX_TIMEOUT_CLR |=> RX_TIMEOUT_RAW_FLAG)
		else $error("clear beat a timeout in the same cycle");

	a_irq_needs_mask: assert property (
		@(posedge MCLK) disable iff (!RESETN)
		RX_TIMEOUT_IRQ |-> RX_TIMEOUT_RAW_FLAG && $past(RX_TIMEOUT_MASK_BIT))
		else $error("interrupt raised without flag and mask");

	a_burst_withheld: assert property (
		@(posedge MCLK) disable iff (!RESETN)
		burst_block |=> !DMA_RX_BREQ && !DMA_TX_BREQ)
		else $error("burst request in LIN or infrared mode");

	a_single_kept: assert property (
		@(posedge MCLK) disable iff (!RESETN)
		RX_DATA_AVAIL && TX_SPACE_AVAIL |=> DMA_RX_SREQ && DMA_TX_SREQ)
		else $error("single request lost");

	a_txd_break: assert property (
		@(posedge MCLK) disable iff (!RESETN)
		brk.start |=> ##1 !TXD)
		else $error("line not low after break start");

	a_raw_refused: assert property (
		@(posedge MCLK) disable iff (!RESETN)
		REV_AFFECTED && !RX_TIMEOUT_MASK_BIT && !RX_TIMEOUT_RAW_FLAG
			|=> !RX_TIMEOUT_RAW_FLAG)
		else $error("masked timeout flagged on affected part");

	a_raw_sticky: assert property (
		@(posedge MCLK) disable iff (!RESETN)
		RX_TIMEOUT_RAW_FLAG && !RX_TIMEOUT_CLR |=> RX_TIMEOUT_RAW_FLAG)
		else $error("raw timeout flag dropped without clear");

	a_raw_cleared: assert property (
		@(posedge MCLK) disable iff (!RESETN)
		RX_TIMEOUT_CLR && !to_set |=> !RX_TIMEOUT_RAW_FLAG)
		else $error("raw timeout flag kept after clear");

	a_irq_follows: assert property (
		@(posedge MCLK) disable iff (!RESETN)
		RX_TIMEOUT_MASK_BIT
			&& (to_set || (RX_TIMEOUT_RAW_FLAG && !RX_TIMEOUT_CLR))
			|=> RX_TIMEOUT_IRQ)
		else $error("interrupt missing with flag and mask");

	a_burst_passes: assert property (
		@(posedge MCLK) disable iff (!RESETN)
		!burst_block && RX_BURST_AVAIL && TX_BURST_SPACE
			|=> DMA_RX_BREQ && DMA_TX_BREQ)
		else $error("burst request lost outside LIN and infrared");

	a_single_idle: assert property (
		@(posedge MCLK) disable iff (!RESETN)
		!RX_DATA_AVAIL && !TX_SPACE_AVAIL
			|=> !DMA_RX_SREQ && !DMA_TX_SREQ)
		else $error("single request without data or space");

	a_start_refused: assert property (
		@(posedge MCLK) disable iff (!RESETN)
		BREAK_START && !LIN_MASTER_EN && !brk.busy |=> !brk.busy)
		else $error("break started with LIN master off");

	a_done_pulse: assert property (
		@(posedge MCLK) disable iff (!RESETN)
		BREAK_DONE |=> !BREAK_DONE)
		else $error("break done held longer than one cycle");

	// ************************************************************
	// Break line monitor
	// ************************************************************
	localparam int LEN_SPEC = int'(BRK_BASE_SPEC);
	localparam int LEN_REV = int'(BRK_BASE_REV);

	int txd_low_cnt;
	int txd_exp_cnt;

	always_ff @(posedge MCLK or negedge RESETN) begin
		if (!RESETN) begin
			txd_low_cnt <= 0;
			txd_exp_cnt <= 0;
		end else if (brk.start) begin
			txd_low_cnt <= 0;
			txd_exp_cnt <= BAUD_DIV * (int'(BREAK_LENGTH_FIELD)
				+ (REV_AFFECTED ? LEN_REV : LEN_SPEC));
		end else if (!TXD) begin
			txd_low_cnt <= txd_low_cnt + 1;
		end
	end

	sequence seq_line_rise;
		$rose(TXD);
	endsequence

	sequence seq_done_idle;
		BREAK_DONE ##1 !BREAK_BUSY;
	endsequence

	a_break_len_code: assert property (
		@(posedge MCLK) disable iff (!RESETN)
		seq_line_rise |-> txd_low_cnt == txd_exp_cnt)
		else $error("line low time does not match length code");

	a_break_end_seq: assert property (
		@(posedge MCLK) disable iff (!RESETN)
		seq_line_rise |-> seq_done_idle)
		else $error("line release not followed by done and idle");

	a_txd_idle: assert property (
		@(posedge MCLK) disable iff (!RESETN)
		!BREAK_BUSY |-> TXD)
		else $error("line low while no break is running");

endmodule : ulb_top

// ===== dv/ulb_lin_node.sv
`timescale 1ns/1ps
// ************************************************************
// Remote LIN node: measures each low stretch on the line
// ************************************************************
module ulb_lin_node (
	input wire logic clk,
	input wire logic txd,
	output int low_len
);
	int cnt = 0;
	always @(posedge clk) begin
		if (!txd) begin
			cnt <= cnt + 1;
		end else if (cnt != 0) begin
			low_len <= cnt;
			cnt <= 0;
		end
	end
endmodule : ulb_lin_node

// ===== dv/ulb_top_tb.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin samples_checked++; if ((e) !== (g)) begin \
	failures++; $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
// ************************************************************
// Bench top
// ************************************************************
module ulb_top_tb;
	import ulb_pkg::*;
	localparam int BD = 2;
	logic mclk = 0, resetn = 0, rev = 0, evt = 0, mask = 0, clr = 0;
	logic lin = 0, ir = 0, brk_start = 0, rda = 0, rba = 0, tsa = 0;
	logic tbs = 0, raw, irq, txd, busy, done, rxs, rxb, txs, txb;
	logic [1:0] code = 2'h0;
	logic [31:0] seed;
	int failures = 0, samples_checked = 0, low_len;

	ulb_top #(.BAUD_DIV(BD)) dut (.MCLK(mclk), .RESETN(resetn),
		.REV_AFFECTED(rev), .RX_TIMEOUT_EVT(evt),
		.RX_TIMEOUT_MASK_BIT(mask), .RX_TIMEOUT_CLR(clr),
		.RX_TIMEOUT_RAW_FLAG(raw), .RX_TIMEOUT_IRQ(irq),
		.LIN_MASTER_EN(lin), .INFRARED_SERIAL_MODE(ir),
		.BREAK_LENGTH_FIELD(code), .BREAK_START(brk_start), .TXD(txd),
		.BREAK_BUSY(busy), .BREAK_DONE(done), .RX_DATA_AVAIL(rda),
		.RX_BURST_AVAIL(rba), .TX_SPACE_AVAIL(tsa), .TX_BURST_SPACE(tbs),
		.DMA_RX_SREQ(rxs), .DMA_RX_BREQ(rxb), .DMA_TX_SREQ(txs),
		.DMA_TX_BREQ(txb));
	ulb_lin_node node (.clk(mclk), .txd(txd), .low_len(low_len));

	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h0);
	endfunction : lfsr

	task automatic step();
		@(posedge mclk);
		#1;
	endtask : step

	task automatic test_done();
		$display("checked %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : test_done

	task automatic wait_done();
		int i;
		for (i = 0; i < 100 && done !== 1'b1; i++) begin
			step();
		end
		step();
		if (i == 100 || busy !== 1'b0) begin
			failures++;
			test_done();
		end
	endtask : wait_done

	initial begin
		forever #12.5 mclk = ~mclk;
	end

	initial begin
		seed = 32'h4801636a;
		repeat (2) @(posedge mclk);
		#1 resetn = 1;
		step();
		for (int k = 0; k < 4; k++) begin
			rev = k[1];
			mask = k[0];
			clr = 1;
			step();
			clr = 0;
			evt = 1;
			step();
			evt = 0;
			`CHK("raw set", !rev || mask, raw)
			`CHK("irq", mask, irq)
			evt = 1;
			clr = 1;
			step();
			evt = 0;
			`CHK("set wins", !rev || mask, raw)
			step();
			clr = 0;
			`CHK("raw clear", 1'b0, raw)
		end
		$display("timeout test done");
		lin = 1;
		for (int k = 0; k < 8; k++) begin
			rev = k[2];
			code = k[1:0];
			brk_start = 1;
			step();
			brk_start = 0;
			wait_done();
			`CHK("break len", (13 + k[1:0] - k[2]) * BD, low_len)
			`CHK("txd idle", 1'b1, txd)
		end
		lin = 0;
		brk_start = 1;
		step();
		brk_start = 0;
		repeat (3) step();
		`CHK("no break", 1'b0, busy)
		$display("break test done");
		for (int k = 0; k < 32; k++) begin
			seed = lfsr(seed);
			{rev, lin, ir, rda, rba, tsa, tbs} = seed[6:0];
			step();
			`CHK("rx single", rda, rxs)
			`CHK("tx single", tsa, txs)
			`CHK("rx burst", rba & !(rev & (lin | ir)), rxb)
			`CHK("tx burst", tbs & !(rev & (lin | ir)), txb)
		end
		$display("dma test done");
		test_done();
	end
endmodule : ulb_top_tb
